// file: src/dtc_defines.vh
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// register indices; byte address is four times the index
`define DTC_IDX_CMPB        6'h28
`define DTC_IDX_CMPA        6'h2a
`define DTC_IDX_T1CNT       6'h2c
`define DTC_IDX_T1CFGB      6'h2e
`define DTC_IDX_T1CFGA      6'h2f
`define DTC_IDX_CAPT        6'h26
`define DTC_IDX_T0CNT       6'h30
`define DTC_IDX_T0CFG       6'h33
`define DTC_IDX_FLAG        6'h38
`define DTC_IDX_MASK        6'h39
`define DTC_IDX_ACMP        6'h08

// reset values
`define DTC_RST_CFG         8'h00
`define DTC_RST_CNT16       16'h0000

// timer1_config_a fields
`define DTC_CFGA_COMA_HI    7
`define DTC_CFGA_COMA_LO    6
`define DTC_CFGA_COMB_HI    5
`define DTC_CFGA_COMB_LO    4
`define DTC_CFGA_PWM_HI     1
`define DTC_CFGA_PWM_LO     0

// timer1_config_b fields
`define DTC_CFGB_ICNC       7
`define DTC_CFGB_ICES       6
`define DTC_CFGB_CTC        3

// comparator capture control field
`define DTC_ACMP_COMPARATOR_CAPTURE_EN       0

// timer_flag_reg / timer_mask_reg bit positions
`define DTC_FLG_T0OVF       0
`define DTC_FLG_T1OVF       1
`define DTC_FLG_CAP         2
`define DTC_FLG_CMPB        3
`define DTC_FLG_CMPA        4
`define DTC_FLG_W           5

// clock select codes
`define DTC_CS_STOP         3'h0
`define DTC_CS_CK           3'h1
`define DTC_CS_DIV8         3'h2
`define DTC_CS_DIV64        3'h3
`define DTC_CS_DIV256       3'h4
`define DTC_CS_DIV1024      3'h5
`define DTC_CS_EXT_FALL     3'h6
`define DTC_CS_EXT_RISE     3'h7

// prescaler and pwm tops
`define DTC_PRE_W           10
`define DTC_PWM_OFF         2'h0
`define DTC_PWM_8           2'h1
`define DTC_PWM_9           2'h2
`define DTC_TOP_8           16'h00ff
`define DTC_TOP_9           16'h01ff
`define DTC_TOP_10          16'h03ff
`define DTC_T0_MAX          8'hff
`define DTC_T1_MAX          16'hffff

// capture noise filter sample count
`define DTC_FILT_N          4

// bus response codes
`define DTC_RESP_OKAY       2'h0
`define DTC_RESP_SLVERR     2'h2

`endif

// file: src/dtc_pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser for asynchronous pins; a change counts only once
// stages two and three agree, which rejects a one-cycle metastable blip
module dtc_pin_sync #(
  parameter W = 4
) (
  input  wire         mclk_i,
  input  wire         srst_i,
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] level_o,
  output reg  [W-1:0] rise_o,
  output reg  [W-1:0] fall_o
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  wire [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [W-1:0] nxt_level = (agree & s2_ff) | (~agree & level_o);

  // stage one feeds stage two only
  always @(posedge mclk_i) begin
    if (srst_i) begin
      s1_ff   <= {W{1'b0}};
      s2_ff   <= {W{1'b0}};
      s3_ff   <= {W{1'b0}};
      level_o <= {W{1'b0}};
      rise_o  <= {W{1'b0}};
      fall_o  <= {W{1'b0}};
    end else begin
      s1_ff   <= pin_i;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      level_o <= nxt_level;
      rise_o  <= nxt_level & ~level_o;
      fall_o  <= ~nxt_level & level_o;
    end
  end

endmodule

`default_nettype wire

// file: src/dtc_timer_unit.v
// Summary of operation
// - one free 10-bit prescaler gives taps CK/8, CK/64, CK/256, CK/1024.
// - timer 0 select: stop, CK, four taps, pin falling, pin rising.
// - external count pins are sampled and synchronised on the system clock.
// - pin modes count pin transitions whatever the pin direction.
// - timer 0 config bits 7..3 read zero; only bits 2..0 write.
// - timer 0 counts up, readable and writable, resumes after a write.
// - timer 0 overflow flag in shared flag register, enable in mask register.
// - timer 1 overflow, compares and capture have own flags and enables.
// - timer 1 compares against A and B, optional clear on A, pin actions.
// - 8/9/10-bit centred, glitch-free dual PWM from counter and compares.
// - qualified capture event copies timer 1 count into capture register.
// - comparator output may replace capture pin as trigger source.
// - with filter on, four equal samples are needed before capture.
// - config A: mode A bits 7:6, mode B 5:4, zeros 3:2, PWM 1:0.
// - non-PWM compare mode: 0 disconnect, 1 toggle, 2 clear, 3 set.
// - in PWM mode the compare mode bits select PWM pin behaviour.
// - PWM select: 0 off, 1 8-bit, 2 9-bit, 3 10-bit.
// - capture edge select: clear means falling edge, set means rising.
// - clear-on-match zeroes timer 1 after compare A match; ignored in PWM.
// - timer 1 clock select uses the same coding as timer 0.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.vh"

module dtc_timer_unit #(
  parameter AW = 8
) (
  input  wire          mclk_i,
  input  wire          srst_i,
  input  wire [AW-1:0] awaddr_i,
  input  wire          awvalid_i,
  output reg           awready_o,
  input  wire [31:0]   wdata_i,
  input  wire [3:0]    wstrb_i,
  input  wire          wvalid_i,
  output reg           wready_o,
  output reg  [1:0]    bresp_o,
  output reg           bvalid_o,
  input  wire          bready_i,
  input  wire [AW-1:0] araddr_i,
  input  wire          arvalid_i,
  output reg           arready_o,
  output reg  [31:0]   rdata_o,
  output reg  [1:0]    rresp_o,
  output reg           rvalid_o,
  input  wire          rready_i,
  input  wire          count_pin_zero_i,
  input  wire          count_pin_one_i,
  input  wire          capture_input_pin_i,
  input  wire          comparator_out_i,
  output reg           compare_pin_a_o,
  output reg           compare_pin_b_o,
  output reg           cmpa_drive_o,
  output reg           cmpb_drive_o,
  output reg           timer_irq_o
);

  // configuration state
  reg [2:0]               t0_cs_ff;
  reg [7:0]               t0_cnt_ff;
  reg [1:0]               coma_ff;
  reg [1:0]               comb_ff;
  reg [1:0]               pwm_ff;
  reg                     icnc_ff;
  reg                     ices_ff;
  reg                     ctc_ff;
  reg [2:0]               t1_cs_ff;
  reg                     comparator_capture_en_ff;
  reg [15:0]              t1_cnt_ff;
  reg [15:0]              ocra_ff;
  reg [15:0]              ocrb_ff;
  reg [15:0]              ocra_act_ff;
  reg [15:0]              ocrb_act_ff;
  reg [15:0]              icr_ff;
  reg                     dir_dn_ff;
  reg                     upd_ff;
  reg [`DTC_PRE_W-1:0]    pre_ff;
  reg [`DTC_FLG_W-1:0]    flag_ff;
  reg [`DTC_FLG_W-1:0]    mask_ff;
  reg [`DTC_FILT_N-1:0]   filt_sh_ff;
  reg                     filt_lvl_ff;
  reg                     cap_prev_ff;
  // bus state
  reg [AW-1:0]            awaddr_ff;
  reg [31:0]              wdata_ff;
  reg [3:0]               wstrb_ff;
  reg                     aw_held_ff;
  reg                     w_held_ff;

  wire [3:0] sync_lvl;
  wire [3:0] sync_rise;
  wire [3:0] sync_fall;

  // pins read directly, so a pin driven as an output still counts
  dtc_pin_sync #(.W(4)) u_sync (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .pin_i   ({comparator_out_i, capture_input_pin_i, count_pin_one_i, count_pin_zero_i}),
    .level_o (sync_lvl),
    .rise_o  (sync_rise),
    .fall_o  (sync_fall)
  );

  wire tap8    = &pre_ff[2:0];
  wire tap64   = &pre_ff[5:0];
  wire tap256  = &pre_ff[7:0];
  wire tap1024 = &pre_ff;

  function sel_tick;
    input [2:0] cs;
    input       fe;
    input       re;
    begin
      case (cs)
        `DTC_CS_STOP:     sel_tick = 1'b0;
        `DTC_CS_CK:       sel_tick = 1'b1;
        `DTC_CS_DIV8:     sel_tick = tap8;
        `DTC_CS_DIV64:    sel_tick = tap64;
        `DTC_CS_DIV256:   sel_tick = tap256;
        `DTC_CS_DIV1024:  sel_tick = tap1024;
        `DTC_CS_EXT_FALL: sel_tick = fe;
        default:          sel_tick = re;
      endcase
    end
  endfunction

  // byte-lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  st;
    begin
      merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // two-clock spacing of pin transitions is assumed for exact counting
  wire t0_tick = sel_tick(t0_cs_ff, sync_fall[0], sync_rise[0]);
  wire t1_tick = sel_tick(t1_cs_ff, sync_fall[1], sync_rise[1]);

  // write is performed once address and data are both held
  wire       wr_fire = aw_held_ff & w_held_ff & ~bvalid_o;
  wire [5:0] wr_idx  = awaddr_ff[7:2];
  wire       wr_b0   = wr_fire & wstrb_ff[0];
  wire [5:0] rd_idx  = araddr_i[7:2];

  function mapped;
    input [5:0] idx;
    begin
      case (idx)
        `DTC_IDX_CMPB, `DTC_IDX_CMPA, `DTC_IDX_T1CNT, `DTC_IDX_T1CFGB,
        `DTC_IDX_T1CFGA, `DTC_IDX_CAPT, `DTC_IDX_T0CNT, `DTC_IDX_T0CFG,
        `DTC_IDX_FLAG, `DTC_IDX_MASK, `DTC_IDX_ACMP: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  wire [15:0] pwm_top = (pwm_ff == `DTC_PWM_8) ? `DTC_TOP_8 :
                        (pwm_ff == `DTC_PWM_9) ? `DTC_TOP_9 : `DTC_TOP_10;
  wire        pwm_on  = (pwm_ff != `DTC_PWM_OFF);

  // timer 1 next state
  reg [15:0] nxt_t1_cnt;
  reg        nxt_dir_dn;
  reg [15:0] nxt_ocra_act;
  reg [15:0] nxt_ocrb_act;
  reg        t1_ovf;
  always @* begin
    nxt_t1_cnt   = t1_cnt_ff;
    nxt_dir_dn   = dir_dn_ff;
    nxt_ocra_act = ocra_act_ff;
    nxt_ocrb_act = ocrb_act_ff;
    t1_ovf       = 1'b0;
    if (!pwm_on) begin
      nxt_ocra_act = ocra_ff;
      nxt_ocrb_act = ocrb_ff;
      nxt_dir_dn   = 1'b0;
    end
    if (wr_fire && wr_idx == `DTC_IDX_T1CNT) begin
      nxt_t1_cnt = merge16(t1_cnt_ff, wdata_ff[15:0], wstrb_ff[1:0]);
    end else if (t1_tick) begin
      if (!pwm_on) begin
        // clear after compare A match, skipped in pwm
        if (ctc_ff && t1_cnt_ff == ocra_act_ff) begin
          nxt_t1_cnt = `DTC_RST_CNT16;
        end else begin
          nxt_t1_cnt = t1_cnt_ff + 16'h0001;
          t1_ovf     = (t1_cnt_ff == `DTC_T1_MAX);
        end
      end else if (!dir_dn_ff) begin
        // compares reload only at top, so a pulse is never cut short
        if (t1_cnt_ff >= pwm_top) begin
          nxt_dir_dn   = 1'b1;
          nxt_t1_cnt   = pwm_top - 16'h0001;
          nxt_ocra_act = ocra_ff;
          nxt_ocrb_act = ocrb_ff;
        end else begin
          nxt_t1_cnt = t1_cnt_ff + 16'h0001;
        end
      end else if (t1_cnt_ff == 16'h0000) begin
        nxt_dir_dn = 1'b0;
        nxt_t1_cnt = 16'h0001;
        t1_ovf     = 1'b1;
      end else begin
        nxt_t1_cnt = t1_cnt_ff - 16'h0001;
      end
    end
  end

  // match checked the cycle after the count moves
  wire match_a = upd_ff & (t1_cnt_ff == ocra_act_ff);
  wire match_b = upd_ff & (t1_cnt_ff == ocrb_act_ff);

  // comparator may replace the capture pin
  wire cap_src = comparator_capture_en_ff ? sync_lvl[3] : sync_lvl[2];
  // filtered level moves only after four equal samples
  wire nxt_filt = (&filt_sh_ff) ? 1'b1 : (~|filt_sh_ff) ? 1'b0 : filt_lvl_ff;
  wire cap_lvl  = icnc_ff ? filt_lvl_ff : cap_src;
  wire cap_evt  = ices_ff ? (cap_lvl & ~cap_prev_ff) : (~cap_lvl & cap_prev_ff);

  // timer 0 overflow at wrap from max
  wire t0_wr  = wr_fire && wr_idx == `DTC_IDX_T0CNT && wstrb_ff[0];
  wire t0_ovf = ~t0_wr & t0_tick & (t0_cnt_ff == `DTC_T0_MAX);

  // event flags; a set in the clearing cycle wins
  wire [`DTC_FLG_W-1:0] flg_set = {match_a, match_b, cap_evt, t1_ovf, t0_ovf};
  wire [`DTC_FLG_W-1:0] flg_clr = (wr_b0 && wr_idx == `DTC_IDX_FLAG) ? wdata_ff[`DTC_FLG_W-1:0]
                                                                     : {`DTC_FLG_W{1'b0}};
  wire [`DTC_FLG_W-1:0] nxt_flag = (flag_ff & ~flg_clr) | flg_set;

  // counters, capture and flags
  always @(posedge mclk_i) begin
    if (srst_i) begin
      pre_ff      <= {`DTC_PRE_W{1'b0}};
      t0_cnt_ff   <= 8'h00;
      t1_cnt_ff   <= `DTC_RST_CNT16;
      dir_dn_ff   <= 1'b0;
      upd_ff      <= 1'b0;
      ocra_act_ff <= `DTC_RST_CNT16;
      ocrb_act_ff <= `DTC_RST_CNT16;
      icr_ff      <= `DTC_RST_CNT16;
      flag_ff     <= {`DTC_FLG_W{1'b0}};
      filt_sh_ff  <= {`DTC_FILT_N{1'b0}};
      filt_lvl_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      timer_irq_o <= 1'b0;
    end else begin
      pre_ff      <= pre_ff + 10'h001;
      // write takes priority, counting resumes next cycle
      if (t0_wr)
        t0_cnt_ff <= wdata_ff[7:0];
      else if (t0_tick)
        t0_cnt_ff <= t0_cnt_ff + 8'h01;
      t1_cnt_ff   <= nxt_t1_cnt;
      dir_dn_ff   <= nxt_dir_dn;
      upd_ff      <= t1_tick;
      ocra_act_ff <= nxt_ocra_act;
      ocrb_act_ff <= nxt_ocrb_act;
      if (cap_evt)
        icr_ff <= t1_cnt_ff;
      flag_ff     <= nxt_flag;
      filt_sh_ff  <= {filt_sh_ff[`DTC_FILT_N-2:0], cap_src};
      filt_lvl_ff <= nxt_filt;
      cap_prev_ff <= cap_lvl;
      timer_irq_o <= |(nxt_flag & mask_ff);
    end
  end

  // compare pin actions
  // drive outputs tell the port logic when the timer owns the pin
  always @(posedge mclk_i) begin
    if (srst_i) begin
      compare_pin_a_o <= 1'b0;
      compare_pin_b_o <= 1'b0;
      cmpa_drive_o    <= 1'b0;
      cmpb_drive_o    <= 1'b0;
    end else if (pwm_on) begin
      // mode 2 clears on up-count match, mode 3 inverts; 0 and 1 release
      cmpa_drive_o <= coma_ff[1];
      cmpb_drive_o <= comb_ff[1];
      if (match_a && coma_ff[1])
        compare_pin_a_o <= dir_dn_ff ^ coma_ff[0];
      if (match_b && comb_ff[1])
        compare_pin_b_o <= dir_dn_ff ^ comb_ff[0];
    end else begin
      cmpa_drive_o <= |coma_ff;
      cmpb_drive_o <= |comb_ff;
      if (match_a)
        compare_pin_a_o <= coma_ff[1] ? coma_ff[0] : (compare_pin_a_o ^ coma_ff[0]);
      if (match_b)
        compare_pin_b_o <= comb_ff[1] ? comb_ff[0] : (compare_pin_b_o ^ comb_ff[0]);
    end
  end

  // software-written configuration
  always @(posedge mclk_i) begin
    if (srst_i) begin
      t0_cs_ff <= 3'h0;
      coma_ff  <= 2'h0;
      comb_ff  <= 2'h0;
      pwm_ff   <= 2'h0;
      icnc_ff  <= 1'b0;
      ices_ff  <= 1'b0;
      ctc_ff   <= 1'b0;
      t1_cs_ff <= 3'h0;
      comparator_capture_en_ff  <= 1'b0;
      mask_ff  <= {`DTC_FLG_W{1'b0}};
      ocra_ff  <= `DTC_RST_CNT16;
      ocrb_ff  <= `DTC_RST_CNT16;
    end else begin
      if (wr_b0 && wr_idx == `DTC_IDX_T0CFG)
        t0_cs_ff <= wdata_ff[2:0];
      if (wr_b0 && wr_idx == `DTC_IDX_T1CFGA) begin
        coma_ff <= wdata_ff[`DTC_CFGA_COMA_HI:`DTC_CFGA_COMA_LO];
        comb_ff <= wdata_ff[`DTC_CFGA_COMB_HI:`DTC_CFGA_COMB_LO];
        pwm_ff  <= wdata_ff[`DTC_CFGA_PWM_HI:`DTC_CFGA_PWM_LO];
      end
      if (wr_b0 && wr_idx == `DTC_IDX_T1CFGB) begin
        icnc_ff  <= wdata_ff[`DTC_CFGB_ICNC];
        ices_ff  <= wdata_ff[`DTC_CFGB_ICES];
        ctc_ff   <= wdata_ff[`DTC_CFGB_CTC];
        t1_cs_ff <= wdata_ff[2:0];
      end
      if (wr_b0 && wr_idx == `DTC_IDX_ACMP)
        comparator_capture_en_ff <= wdata_ff[`DTC_ACMP_COMPARATOR_CAPTURE_EN];
      if (wr_b0 && wr_idx == `DTC_IDX_MASK)
        mask_ff <= wdata_ff[`DTC_FLG_W-1:0];
      if (wr_fire && wr_idx == `DTC_IDX_CMPA)
        ocra_ff <= merge16(ocra_ff, wdata_ff[15:0], wstrb_ff[1:0]);
      if (wr_fire && wr_idx == `DTC_IDX_CMPB)
        ocrb_ff <= merge16(ocrb_ff, wdata_ff[15:0], wstrb_ff[1:0]);
    end
  end

  // read mux; reserved bits read as zero
  reg [15:0] rd_val;
  always @* begin
    case (rd_idx)
      `DTC_IDX_CMPB:   rd_val = ocrb_ff;
      `DTC_IDX_CMPA:   rd_val = ocra_ff;
      `DTC_IDX_T1CNT:  rd_val = t1_cnt_ff;
      `DTC_IDX_T1CFGB: rd_val = {8'h00, icnc_ff, ices_ff, 2'b00, ctc_ff, t1_cs_ff};
      `DTC_IDX_T1CFGA: rd_val = {8'h00, coma_ff, comb_ff, 2'b00, pwm_ff};
      `DTC_IDX_CAPT:   rd_val = icr_ff;
      `DTC_IDX_T0CNT:  rd_val = {8'h00, t0_cnt_ff};
      `DTC_IDX_T0CFG:  rd_val = {13'h0000, t0_cs_ff};
      `DTC_IDX_FLAG:   rd_val = {11'h000, flag_ff};
      `DTC_IDX_MASK:   rd_val = {11'h000, mask_ff};
      `DTC_IDX_ACMP:   rd_val = {15'h0000, comparator_capture_en_ff};
      default:         rd_val = 16'h0000;
    endcase
  end

  // axi4-lite channels; one write and one read outstanding keeps this small
  wire aw_take      = awvalid_i & awready_o;
  wire w_take       = wvalid_i & wready_o;
  wire nxt_aw_held  = (aw_held_ff & ~wr_fire) | aw_take;
  wire nxt_w_held   = (w_held_ff & ~wr_fire) | w_take;
  wire nxt_bvalid   = wr_fire | (bvalid_o & ~bready_i);
  wire ar_take      = arvalid_i & arready_o;
  wire nxt_rvalid   = ar_take | (rvalid_o & ~rready_i);
  always @(posedge mclk_i) begin
    if (srst_i) begin
      awaddr_ff  <= {AW{1'b0}};
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_o  <= 1'b0;
      wready_o   <= 1'b0;
      bvalid_o   <= 1'b0;
      bresp_o    <= `DTC_RESP_OKAY;
      arready_o  <= 1'b0;
      rvalid_o   <= 1'b0;
      rdata_o    <= 32'h0000_0000;
      rresp_o    <= `DTC_RESP_OKAY;
    end else begin
      if (aw_take)
        awaddr_ff <= awaddr_i;
      if (w_take) begin
        wdata_ff <= wdata_i;
        wstrb_ff <= wstrb_i;
      end
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_o  <= ~nxt_aw_held & ~nxt_bvalid;
      wready_o   <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_o   <= nxt_bvalid;
      if (wr_fire)
        bresp_o <= (mapped(wr_idx) && wr_idx != `DTC_IDX_CAPT) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      arready_o  <= ~nxt_rvalid;
      rvalid_o   <= nxt_rvalid;
      if (ar_take) begin
        rdata_o <= {16'h0000, rd_val};
        rresp_o <= mapped(rd_idx) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/dtc_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.vh"

module dtc_timer_props #(
  parameter AW = 8
) (
  input wire logic          mclk_i,
  input wire logic          srst_i,
  input wire logic          awvalid_i,
  input wire logic          awready_o,
  input wire logic          wvalid_i,
  input wire logic          wready_o,
  input wire logic [1:0]    bresp_o,
  input wire logic          bvalid_o,
  input wire logic          bready_i,
  input wire logic [AW-1:0] araddr_i,
  input wire logic          arvalid_i,
  input wire logic          arready_o,
  input wire logic [31:0]   rdata_o,
  input wire logic [1:0]    rresp_o,
  input wire logic          rvalid_o,
  input wire logic          rready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // both write channels taken together, then the answer two edges on
  sequence s_wr_both;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_wr_answer;
    ##2 bvalid_o;
  endsequence
  sequence s_rd_take;
    arvalid_i && arready_o;
  endsequence

  a_write_answer: assert property (s_wr_both |-> s_wr_answer)
    else $error("write response late");
  a_write_refused: assert property (s_wr_both |=> !awready_o && !wready_o)
    else $error("write ready stayed high");
  a_bresp_stands: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_take |=> rvalid_o && !arready_o)
    else $error("read data late");
  a_rdata_stands: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
    else $error("read data dropped");
  a_rdata_upper: assert property (rvalid_o |-> rdata_o[31:16] == 16'h0000)
    else $error("read upper bits not zero");
  a_unmapped_read: assert property (arvalid_i && arready_o && araddr_i[7:2] == 6'h00
    |=> rresp_o == `DTC_RESP_SLVERR && rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_cfg0_zeros: assert property (arvalid_i && arready_o && araddr_i[7:2] == `DTC_IDX_T0CFG
    |=> rdata_o[7:3] == 5'h00 && rresp_o == `DTC_RESP_OKAY)
    else $error("timer0 config reserved bits set");
  a_cfga_zeros: assert property (arvalid_i && arready_o && araddr_i[7:2] == `DTC_IDX_T1CFGA
    |=> rdata_o[3:2] == 2'h0 && rresp_o == `DTC_RESP_OKAY)
    else $error("timer1 config a reserved bits set");
endmodule

bind dtc_timer_unit dtc_timer_props #(.AW(AW)) u_props (.*);
`default_nettype wire

// file: tb/dtc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// external count source; idles low, so each pulse gives one rise and one fall
module dtc_pin_model (
  input  wire logic mclk_i,
  output var logic  pin_o
);
  initial pin_o = 1'b0;

  // gap sets how slowly the source toggles; three cycles is the quick case
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge mclk_i);
      pin_o <= 1'b1;
      repeat (gap) @(posedge mclk_i);
      pin_o <= 1'b0;
    end
    repeat (10) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// file: tb/test_dtc_timer_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defines.vh"

module test_dtc_timer_unit;
  localparam logic [7:0] A_T0C = {`DTC_IDX_T0CFG, 2'b00};
  localparam logic [7:0] A_T0N = {`DTC_IDX_T0CNT, 2'b00};
  localparam logic [7:0] A_T1A = {`DTC_IDX_T1CFGA, 2'b00};
  localparam logic [7:0] A_FLG = {`DTC_IDX_FLAG, 2'b00};
  localparam logic [7:0] A_MSK = {`DTC_IDX_MASK, 2'b00};
  localparam logic [7:0] A_T1B = {`DTC_IDX_T1CFGB, 2'b00};
  localparam logic [7:0] A_T1N = {`DTC_IDX_T1CNT, 2'b00};
  localparam logic [7:0] A_CPA = {`DTC_IDX_CMPA, 2'b00};
  localparam logic [7:0] A_CPB = {`DTC_IDX_CMPB, 2'b00};
  localparam logic [7:0] A_CAP = {`DTC_IDX_CAPT, 2'b00};
  localparam logic [7:0] A_ACM = {`DTC_IDX_ACMP, 2'b00};
  logic        mclk_i, srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic        capture_input_pin_i, comparator_out_i;
  wire         count_pin_one_i;
  logic [7:0]  awaddr_i, araddr_i;
  logic [31:0] wdata_i, seed;
  logic [3:0]  wstrb_i;
  wire         awready_o, wready_o, bvalid_o, arready_o, rvalid_o, timer_irq_o, count_pin_zero_i;
  wire         compare_pin_a_o, compare_pin_b_o, cmpa_drive_o, cmpb_drive_o;
  wire  [1:0]  bresp_o, rresp_o;
  wire  [31:0] rdata_o;
  logic [33:0] exp_q[$];
  logic [1:0]  exp_b[$];
  int          fails, n_tests, cyc;

  dtc_timer_unit #(.AW(8)) dut (.*);
  dtc_pin_model u_pin (.mclk_i(mclk_i), .pin_o(count_pin_zero_i));
  dtc_pin_model u_pin1 (.mclk_i(mclk_i), .pin_o(count_pin_one_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single-bit levels: pins, drive enables, request
  task automatic chk_lvl(input string nm, input logic e, input logic g);
    chk(nm, {33'h0, e}, {33'h0, g});
  endtask

  // write response codes
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    chk("bresp", {32'h0, e}, {32'h0, g});
  endtask

  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bready stands with the request and drops on the edge that takes the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `DTC_RESP_OKAY);
    exp_b.push_back(er);
    @(posedge mclk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) begin
        bready_i <= 1'b0;
        break;
      end
    end
  endtask

  // expected {rresp, rdata} is queued; the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) begin
        rready_i <= 1'b0;
        break;
      end
    end
  endtask

  // monitor: one queued note per read answer and per write answer
  always @(posedge mclk_i) begin
    if (rvalid_o && rready_i) chk("read", exp_q.pop_front(), {rresp_o, rdata_o});
    if (bvalid_o && bready_i) chk_resp(exp_b.pop_front(), bresp_o);
  end

  // hang guard, generous against the nine hundred or so cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 6'h20;
    {capture_input_pin_i, comparator_out_i} = 2'h0;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = {16'h0000, 32'h0000_0000, 4'hf};
    seed = 32'd71955;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rd(A_T0C, 34'h0);
    rd(A_T1A, 34'h0);
    rd(8'h00, {`DTC_RESP_SLVERR, 32'h0000_0000});
    // every clock code, reserved bits written as ones
    for (int i = 0; i < 8; i++) begin
      wr(A_T0C, 32'h0000_00f8 | i);
      rd(A_T0C, i);
    end
    wr(A_T0C, 32'h0);
    // random values while stopped must read back unchanged, except config A bits 3:2, which read as zero
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(A_T0N, seed);
      rd(A_T0N, {26'h0, seed[7:0]});
      wr(A_T1A, seed);
      rd(A_T1A, {26'h0, seed[7:0] & 8'hf3});
    end
    wr(A_T1A, 32'h0);
    // external pin counting, falling then rising edge, quick then slow source
    for (int m = 6; m < 8; m++) begin
      wr(A_T0C, 32'h0);
      wr(A_T0N, 32'h0);
      wr(A_T0C, m);
      u_pin.pulse(5, 3 * (m - 5));
      rd(A_T0N, 34'h5);
    end
    // overflow with the mask set raises the request
    wr(A_T0C, 32'h0);
    wr(A_MSK, 32'h1);
    wr(A_T0N, 32'hfe);
    wr(A_T0C, `DTC_CS_CK);
    for (int k = 0; k < 30 && timer_irq_o !== 1'b1; k++) @(posedge mclk_i);
    chk_lvl("irq", 1'b1, timer_irq_o);
    wr(A_T0C, 32'h0);
    rd(A_FLG, 34'h1);
    wr(A_FLG, 32'h1);
    rd(A_FLG, 34'h0);
    chk_lvl("irq", 1'b0, timer_irq_o);
    // overflow with the mask clear sets the flag only
    wr(A_MSK, 32'h0);
    wr(A_T0C, `DTC_CS_CK);
    repeat (300) @(posedge mclk_i);
    wr(A_T0C, 32'h0);
    chk_lvl("irq", 1'b0, timer_irq_o);
    rd(A_FLG, 34'h1);
    // the capture word is read-only, so a write is refused
    wr(A_CAP, 32'h0000_0001, `DTC_RESP_SLVERR);
    // timer 1 on pin rises: B toggles at 2, A sets at 3 and clears the count
    wr(A_CPA, 32'h0000_0003);
    wr(A_CPB, 32'h0000_0002);
    wr(A_T1A, 32'h0000_00d0);
    @(posedge mclk_i);
    chk_lvl("drive_a", 1'b1, cmpa_drive_o);
    wr(A_T1B, 32'h0000_000f);
    u_pin1.pulse(5, 3);
    rd(A_T1N, 34'h1);
    rd(A_FLG, 34'h19);
    chk_lvl("pin_a", 1'b1, compare_pin_a_o);
    chk_lvl("pin_b", 1'b1, compare_pin_b_o);
    // mode A clears, mode B released keeps its level
    wr(A_T1A, 32'h0000_0080);
    u_pin1.pulse(2, 3);
    rd(A_T1N, 34'h3);
    chk_lvl("pin_a", 1'b0, compare_pin_a_o);
    chk_lvl("pin_b", 1'b1, compare_pin_b_o);
    chk_lvl("drive_b", 1'b0, cmpb_drive_o);
    // rising capture while timer 1 stands at 3
    wr(A_T1B, 32'h0000_0040);
    capture_input_pin_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rd(A_CAP, 34'h3);
    // filter on: a two-cycle low blip is ignored, a steady fall captures
    wr(A_T1N, 32'h0000_0007);
    wr(A_T1B, 32'h0000_0080);
    wr(A_FLG, 32'h0000_001f);
    capture_input_pin_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    capture_input_pin_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rd(A_FLG, 34'h0);
    capture_input_pin_i <= 1'b0;
    repeat (14) @(posedge mclk_i);
    rd(A_CAP, 34'h7);
    // the comparator replaces the pin as capture source
    wr(A_T1N, 32'h0000_0009);
    wr(A_ACM, 32'h0000_0001);
    comparator_out_i <= 1'b1;
    repeat (14) @(posedge mclk_i);
    comparator_out_i <= 1'b0;
    repeat (14) @(posedge mclk_i);
    rd(A_CAP, 34'h9);
    // 8-bit pwm from fd turns at ff; A matches fc going down and sets the pin
    wr(A_T1N, 32'h0000_00fd);
    wr(A_CPA, 32'h0000_00fc);
    wr(A_T1A, 32'h0000_0081);
    wr(A_T1B, 32'h0000_0007);
    u_pin1.pulse(5, 3);
    rd(A_T1N, 34'hfc);
    chk_lvl("pin_a", 1'b1, compare_pin_a_o);
    complete_run();
  end
endmodule
`default_nettype wire
